// File: logic/ldpms_delay_timer.sv
`timescale 1ns/100ps
module ldpms_delay_timer #(
  parameter int CYCLES = ldpms_pkg::DELAY_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clear,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_q;  // Cycles spent in the current mode

  // Counts oscillator cycles, restarts on each mode entry, then holds
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Holding at the end keeps done high without a wrap glitch
  assign done = (cnt_q == LAST);

  a_timer_hold: assert property (@(posedge clk) disable iff (!rstn)
    done && !clear |=> done)
    else $error("delay timer left its end count");
endmodule

// File: logic/ldpms_pkg.sv
package ldpms_pkg;
  // Register addresses on the host write/read port
  localparam logic [7:0] ADDR_ENABLES   = 8'h08;  // Mode and converter enables
  localparam logic [7:0] ADDR_BOOST_OUT = 8'h0D;  // Output voltage code
  localparam logic [7:0] ADDR_BOOST_FRQ = 8'h0E;  // Switching frequency select
  localparam logic [7:0] ADDR_SOFT_RST  = 8'h60;  // Any write resets the device

  // Field positions inside the enables register
  localparam int BIT_LOW_POWER_EXIT = 6;  // Leaves standby when set
  localparam int BIT_EN_BOOST       = 5;  // Converter enable
  localparam int BIT_EN_AUTOLOAD    = 4;  // Light-load discharge enable

  // Frequency select field positions
  localparam int BIT_FRQ_HI  = 2;  // 1XX selects the fastest clock
  localparam int BIT_FRQ_MID = 1;  // 01X selects the middle clock

  // Reset values
  localparam logic [7:0] RST_ENABLES   = 8'h00;
  localparam logic [7:0] RST_BOOST_OUT = 8'h3F;
  localparam logic [7:0] RST_BOOST_FRQ = 8'h07;

  // Clock and timing figures
  localparam int CLK_KHZ      = 100000;  // Internal oscillator rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_MS     = 10;      // Oscillator settle and soft-start time
  localparam int DELAY_CYC    = DELAY_MS * CLK_KHZ;
  localparam int FSW_HI_KHZ   = 2000;
  localparam int FSW_MID_KHZ  = 1670;
  localparam int FSW_LO_KHZ   = 1000;
  localparam int PER_W        = 8;       // Width of a switching period count
  localparam logic [PER_W-1:0] PER_HI  = PER_W'(CLK_KHZ / FSW_HI_KHZ);
  localparam logic [PER_W-1:0] PER_MID = PER_W'(CLK_KHZ / FSW_MID_KHZ);
  localparam logic [PER_W-1:0] PER_LO  = PER_W'(CLK_KHZ / FSW_LO_KHZ);
  localparam int T_PULSE_NS   = 25;      // Least switch on-time
  localparam logic [PER_W-1:0] MIN_ON_CYC =
    PER_W'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MAX_DUTY_PCT = 90;      // Largest on-time share of a period
  localparam int VSTEP_W      = 4;       // Width of the voltage step index

  // Operating modes
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_STARTUP,
    MODE_BOOST_START,
    MODE_NORMAL
  } ldpms_mode_type;
endpackage

// File: logic/ldpms_sequencer.sv
`timescale 1ns/100ps
module ldpms_sequencer #(
  parameter int DELAY_CYC = ldpms_pkg::DELAY_CYC  // 10 ms in oscillator cycles
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           external_reset_pin_n,
  input  wire logic                           second_supply_ok,
  input  wire logic                           overtemp_shutdown,
  input  wire logic                           wr_en,
  input  wire logic [7:0]                     wr_addr,
  input  wire logic [7:0]                     wr_data,
  input  wire logic                           rd_en,
  input  wire logic [7:0]                     rd_addr,
  output logic [7:0]                          rd_data,
  input  wire logic                           fb_low,
  input  wire logic                           ipk_trip,
  output ldpms_pkg::ldpms_mode_type           mode,
  output logic                                core_power_en,
  output logic                                conv_run,
  output logic                                pfm_mode,
  output logic                                led_force_off,
  output logic                                led_enable,
  output logic                                autoload_en,
  output logic                                sw_gate,
  output logic [ldpms_pkg::VSTEP_W-1:0]       vout_step
);
  localparam int PW = ldpms_pkg::PER_W;

  logic                        rst_meta_q;    // First reset stage
  logic                        rst_sync_q;    // Released reset copy
  logic                        soft_rst_q;    // Pulse after a reset-register write
  logic                        dev_rst;       // Merged device reset
  logic [7:0]                  enables_q;     // Enables register
  logic [7:0]                  boost_out_q;   // Voltage code register
  logic [7:0]                  boost_frq_q;   // Frequency select register
  logic [7:0]                  rd_data_q;     // Read data
  logic                        exit_bit;      // Standby exit bit
  logic                        en_boost;      // Converter enable bit
  logic                        en_boost_q;    // Enable seen last cycle
  logic                        boost_rise;    // Enable went from zero to one
  ldpms_pkg::ldpms_mode_type   state_q;       // Current mode
  ldpms_pkg::ldpms_mode_type   state_d;       // Next mode
  logic                        tmr_clear;     // Restart the delay
  logic                        tmr_done;      // 10 ms reached
  logic [PW-1:0]               period;        // Selected switching period
  logic [PW+7:0]               max_on_w;      // Wide duty product
  logic [PW-1:0]               max_on;        // Largest on-time
  logic [PW-1:0]               per_q;         // Position in the switching period
  logic [PW-1:0]               per_nx;        // Position plus one
  logic                        sw_on_q;       // Switch gate
  logic [ldpms_pkg::VSTEP_W-1:0] vstep_q;     // Voltage step
  logic [ldpms_pkg::VSTEP_W-1:0] vstep_d;

  // Two-stage release of the asynchronous board reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // One-cycle pulse after any write to the reset register, whatever the data
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_en && (wr_addr == ldpms_pkg::ADDR_SOFT_RST);
    end
  end

  // Pin, power-on and soft-reset sources override register writes and the mode
  assign dev_rst = !external_reset_pin_n || !second_supply_ok || soft_rst_q;

  // Register writes; reset wins over a write in the same cycle
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enables_q   <= ldpms_pkg::RST_ENABLES;
      boost_out_q <= ldpms_pkg::RST_BOOST_OUT;
      boost_frq_q <= ldpms_pkg::RST_BOOST_FRQ;
    end else if (dev_rst) begin
      enables_q   <= ldpms_pkg::RST_ENABLES;
      boost_out_q <= ldpms_pkg::RST_BOOST_OUT;
      boost_frq_q <= ldpms_pkg::RST_BOOST_FRQ;
    end else if (wr_en) begin
      // Accepted in every mode, standby included; no ordering needed
      case (wr_addr)
        ldpms_pkg::ADDR_ENABLES:   enables_q   <= wr_data;
        ldpms_pkg::ADDR_BOOST_OUT: boost_out_q <= wr_data;
        ldpms_pkg::ADDR_BOOST_FRQ: boost_frq_q <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Registered read-back; unmapped addresses return zero
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      case (rd_addr)
        ldpms_pkg::ADDR_ENABLES:   rd_data_q <= enables_q;
        ldpms_pkg::ADDR_BOOST_OUT: rd_data_q <= boost_out_q;
        ldpms_pkg::ADDR_BOOST_FRQ: rd_data_q <= boost_frq_q;
        default:                   rd_data_q <= 8'h00;
      endcase
    end
  end
  assign rd_data = rd_data_q;

  assign exit_bit = enables_q[ldpms_pkg::BIT_LOW_POWER_EXIT];
  assign en_boost = enables_q[ldpms_pkg::BIT_EN_BOOST];

  // Edge of the converter enable, so normal mode restarts soft-start once
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      en_boost_q <= 1'b0;
    end else begin
      en_boost_q <= en_boost;
    end
  end
  assign boost_rise = en_boost && !en_boost_q;

  // Next mode
  always_comb begin
    state_d = state_q;
    if (dev_rst || !exit_bit) begin
      state_d = ldpms_pkg::MODE_STANDBY;
    end else begin
      case (state_q)
        ldpms_pkg::MODE_STANDBY: begin
          state_d = ldpms_pkg::MODE_STARTUP;
        end
        ldpms_pkg::MODE_STARTUP: begin
          // Overtemperature holds here and keeps the delay from finishing
          if (!overtemp_shutdown && tmr_done) begin
            state_d = en_boost ? ldpms_pkg::MODE_BOOST_START : ldpms_pkg::MODE_NORMAL;
          end
        end
        ldpms_pkg::MODE_BOOST_START: begin
          if (overtemp_shutdown) begin
            state_d = ldpms_pkg::MODE_STARTUP;
          end else if (!en_boost || tmr_done) begin
            state_d = ldpms_pkg::MODE_NORMAL;
          end
        end
        ldpms_pkg::MODE_NORMAL: begin
          if (overtemp_shutdown) begin
            state_d = ldpms_pkg::MODE_STARTUP;
          end else if (boost_rise) begin
            state_d = ldpms_pkg::MODE_BOOST_START;
          end
        end
        default: state_d = ldpms_pkg::MODE_STANDBY;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= ldpms_pkg::MODE_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end
  assign mode = state_q;

  // Delay restarts on each mode change and while too hot in startup
  assign tmr_clear = (state_d != state_q) ||
                     (state_q == ldpms_pkg::MODE_STARTUP && overtemp_shutdown);

  ldpms_delay_timer #(
    .CYCLES (DELAY_CYC)
  ) u_delay (
    .clk   (clk),
    .rstn  (rst_sync_q),
    .clear (tmr_clear),
    .done  (tmr_done)
  );

  // Mode-driven controls; the analog blocks stay off in standby
  assign core_power_en = (state_q != ldpms_pkg::MODE_STANDBY);
  assign conv_run      = (state_q == ldpms_pkg::MODE_BOOST_START) ||
                         (state_q == ldpms_pkg::MODE_NORMAL && en_boost);
  assign pfm_mode      = (state_q == ldpms_pkg::MODE_BOOST_START);
  assign led_force_off = (state_q == ldpms_pkg::MODE_BOOST_START);
  assign led_enable    = (state_q == ldpms_pkg::MODE_NORMAL);
  assign autoload_en   = conv_run && enables_q[ldpms_pkg::BIT_EN_AUTOLOAD];

  // Frequency decode, all periods counted on the oscillator clock
  always_comb begin
    if (boost_frq_q[ldpms_pkg::BIT_FRQ_HI]) begin
      period = ldpms_pkg::PER_HI;
    end else if (boost_frq_q[ldpms_pkg::BIT_FRQ_MID]) begin
      period = ldpms_pkg::PER_MID;
    end else begin
      period = ldpms_pkg::PER_LO;
    end
  end

  // Duty ceiling as a share of the period, truncated to whole cycles
  assign max_on_w = ((PW + 8)'(period) * (PW + 8)'(ldpms_pkg::MAX_DUTY_PCT)) / (PW + 8)'(100);
  assign max_on   = max_on_w[PW-1:0];
  assign per_nx   = per_q + PW'(1);

  // Switching period counter
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      per_q <= '0;
    end else if (!conv_run || per_nx >= period) begin
      per_q <= '0;
    end else begin
      per_q <= per_nx;
    end
  end

  // Switch gate: starts each period, ends on current trip after the least
  // width, or at the duty ceiling; in PFM only when the output sags
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sw_on_q <= 1'b0;
    end else if (!conv_run) begin
      sw_on_q <= 1'b0;
    end else if (per_nx >= period) begin
      sw_on_q <= !pfm_mode || fb_low;
    end else if (sw_on_q) begin
      sw_on_q <= (per_nx < max_on) &&
                 !(ipk_trip && per_nx >= ldpms_pkg::MIN_ON_CYC);
    end
  end
  assign sw_gate = sw_on_q;

  // Highest set bit of the code picks one of nine feedback taps
  always_comb begin
    vstep_d = '0;
    for (int i = 0; i < 8; i++) begin
      if (boost_out_q[i]) begin
        vstep_d = ldpms_pkg::VSTEP_W'(i + 1);
      end
    end
  end

  // Registered tap select for the divider
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      vstep_q <= '0;
    end else begin
      vstep_q <= vstep_d;
    end
  end
  assign vout_step = vstep_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_q);

  a_reset_clears: assert property (dev_rst |=> !exit_bit && boost_frq_q == ldpms_pkg::RST_BOOST_FRQ &&
                                   boost_out_q == ldpms_pkg::RST_BOOST_OUT)
    else $error("registers not at default after reset");
  a_reset_standby: assert property (dev_rst |=> state_q == ldpms_pkg::MODE_STANDBY)
    else $error("reset did not force standby");
  a_pin_por_reset: assert property (!external_reset_pin_n || !second_supply_ok |=> !core_power_en)
    else $error("pin or power-on reset did not power down");
  a_soft_reset: assert property (wr_en && wr_addr == ldpms_pkg::ADDR_SOFT_RST |=> dev_rst ##1 !exit_bit)
    else $error("reset register write ignored");
  // The gate flop follows conv_run one edge later, so it is checked a cycle after the mode
  a_standby_off: assert property (!exit_bit |=> !core_power_en && !conv_run ##1 !sw_gate)
    else $error("circuits active with exit bit low");
  a_standby_write: assert property (state_q == ldpms_pkg::MODE_STANDBY && wr_en && !dev_rst &&
                                    wr_addr == ldpms_pkg::ADDR_BOOST_OUT |=> boost_out_q == $past(wr_data))
    else $error("write in standby lost");
  // Exit bit and reset are taken from the deciding cycle, not the one after
  a_startup_wait: assert property ($past(state_q) == ldpms_pkg::MODE_STARTUP && $past(exit_bit) &&
                                   !$past(dev_rst) && state_q != ldpms_pkg::MODE_STARTUP |-> $past(tmr_done))
    else $error("startup left before delay");
  a_overtemp: assert property (overtemp_shutdown && exit_bit && !dev_rst &&
                               state_q != ldpms_pkg::MODE_STANDBY |=> state_q == ldpms_pkg::MODE_STARTUP)
    else $error("overtemperature did not return to startup");
  a_softstart_leds: assert property (pfm_mode |-> led_force_off && !led_enable)
    else $error("LEDs not forced off in soft-start");
  a_min_pulse: assert property ($fell(sw_on_q) && $past(conv_run) |-> $past(sw_on_q, 3))
    else $error("switch pulse shorter than least width");
  a_max_duty: assert property (sw_on_q |-> per_q < max_on)
    else $error("switch on past duty limit");
  a_vout_range: assert property (vout_step <= 4'h8)
    else $error("voltage step out of range");
  a_autoload_off: assert property (!enables_q[ldpms_pkg::BIT_EN_AUTOLOAD] |-> !autoload_en)
    else $error("discharge on with bit clear");

  c_normal: cover property (state_q == ldpms_pkg::MODE_NORMAL && conv_run);
  c_boost_restart: cover property (state_q == ldpms_pkg::MODE_NORMAL ##1 state_q == ldpms_pkg::MODE_BOOST_START);
  c_overtemp: cover property (state_q == ldpms_pkg::MODE_NORMAL ##1 state_q == ldpms_pkg::MODE_STARTUP);
  c_soft_reset: cover property (soft_rst_q && state_q == ldpms_pkg::MODE_NORMAL);
endmodule

// File: sim/ldpms_host_model.sv
`timescale 1ns/100ps
// Host side of the register port, driving requests on the falling edge
module ldpms_host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            rd_en,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);
  // Idle bus shows a pattern, never a value the design could lean on
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'hFF;
    wr_data = 8'hFF;
    rd_en   = 1'b0;
    rd_addr = 8'hFF;
  end

  // One write; held across the taking edge, any address in any order
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    wr_en   = 1'b1;
    wr_addr = addr;
    wr_data = data;
    @(negedge clk);
    wr_en   = 1'b0;
    // Released lines flip so a stale address is never mistaken for a request
    wr_addr = ~addr;
    wr_data = ~data;
  endtask

  // One read; the answer is registered, so it is settled one edge later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = addr;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~addr;
    data    = rd_data;
  endtask
endmodule

// File: sim/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the power mode sequencer
module testbench;
  localparam int DLY  = 120;    // Shortened 10 ms delay; longer than the slowest switching period
  localparam int CEIL = 20000;  // Cycle ceiling; the tests need a few thousand

  logic                            clk;                   // 100 MHz clock
  logic                            resetn;                // Board reset, active low
  logic                            external_reset_pin_n;  // Reset pin, active low
  logic                            second_supply_ok;      // Low holds power-on reset
  logic                            overtemp_shutdown;     // Thermal flag
  logic                            wr_en;                 // Host write strobe
  logic [7:0]                      wr_addr;               // Host write address
  logic [7:0]                      wr_data;               // Host write data
  logic                            rd_en;                 // Host read strobe
  logic [7:0]                      rd_addr;               // Host read address
  logic [7:0]                      rd_data;               // Read answer
  logic                            fb_low;                // Feedback below target
  logic                            ipk_trip;              // Peak current trip
  ldpms_pkg::ldpms_mode_type       mode;                  // Operating mode
  logic                            core_power_en;         // Reference and bias on
  logic                            conv_run;              // Converter running
  logic                            pfm_mode;              // Soft-start flag
  logic                            led_force_off;         // LEDs held off
  logic                            led_enable;            // LEDs allowed
  logic                            autoload_en;           // Discharge path on
  logic                            sw_gate;               // Switch gate
  logic [ldpms_pkg::VSTEP_W-1:0]   vout_step;             // Voltage step index
  int                              n_mismatch;            // Failed comparisons
  int                              num_checks;            // All comparisons
  int                              cyc;                   // Timeout counter
  logic [7:0]                      rd_v;                  // Last read value
  int                              w;                     // Gate high time
  int                              p;                     // Gate period
  logic                            seen;                  // Any gate pulse seen
  logic [7:0]                      frq_code [5];          // Frequency codes tried
  logic [7:0]                      frq_per  [5];          // Expected periods

  ldpms_sequencer #(.DELAY_CYC(DLY)) ldpms_sequencer_inst (
    .clk(clk), .resetn(resetn), .external_reset_pin_n(external_reset_pin_n),
    .second_supply_ok(second_supply_ok), .overtemp_shutdown(overtemp_shutdown),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .fb_low(fb_low), .ipk_trip(ipk_trip), .mode(mode),
    .core_power_en(core_power_en), .conv_run(conv_run), .pfm_mode(pfm_mode),
    .led_force_off(led_force_off), .led_enable(led_enable), .autoload_en(autoload_en),
    .sw_gate(sw_gate), .vout_step(vout_step)
  );

  ldpms_host_model ldpms_host_model_inst (
    .clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data)
  );

  // Free-running clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Verdict and end of run, the single place the run stops
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compare an eight-bit result
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a single flag
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for a mode; arriving before lo cycles counts as early
  task automatic wait_mode(input ldpms_pkg::ldpms_mode_type exp, input int lo, input int hi);
    int n;
    n = 0;
    while (mode !== exp && n < hi) begin
      @(negedge clk);
      n++;
    end
    cmp_val({6'h00, mode}, {6'h00, exp});
    cmp_bit(n >= lo, 1'b1);
  endtask

  // Read a register and compare it
  task automatic rd_cmp(input logic [7:0] addr, input logic [7:0] exp);
    ldpms_host_model_inst.read_reg(addr, rd_v);
    cmp_val(rd_v, exp);
  endtask

  // Measure one full gate pulse; the first partial one is skipped
  task automatic sw_measure(output int wh, output int pr);
    int k;
    wh = 0;
    for (k = 0; k < 300 && sw_gate !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 300 && sw_gate !== 1'b1; k++) @(negedge clk);
    while (sw_gate === 1'b1 && wh < 300) begin
      @(negedge clk);
      wh++;
    end
    pr = wh;
    while (sw_gate !== 1'b1 && pr < 300) begin
      @(negedge clk);
      pr++;
    end
  endtask

  // Hang guard: a run past the ceiling is a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    resetn = 1'b0;
    external_reset_pin_n = 1'b1;
    second_supply_ok = 1'b1;
    overtemp_shutdown = 1'b0;
    fb_low = 1'b1;  // Keeps soft-start pulsing unless a test lowers it
    ipk_trip = 1'b0;
    frq_code = '{8'h07, 8'h04, 8'h03, 8'h02, 8'h01};
    frq_per  = '{ldpms_pkg::PER_HI, ldpms_pkg::PER_HI, ldpms_pkg::PER_MID,
                 ldpms_pkg::PER_MID, ldpms_pkg::PER_LO};
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    // Defaults after reset, standby with everything off
    wait_mode(ldpms_pkg::MODE_STANDBY, 0, 1);
    cmp_bit(core_power_en, 1'b0);
    rd_cmp(ldpms_pkg::ADDR_ENABLES, 8'h00);
    rd_cmp(ldpms_pkg::ADDR_BOOST_OUT, 8'h3F);
    rd_cmp(ldpms_pkg::ADDR_BOOST_FRQ, 8'h07);
    rd_cmp(8'h55, 8'h00);
    // Voltage codes written in standby map to nine steps
    for (int i = 0; i < 9; i++) begin
      ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_BOOST_OUT, 8'((9'h001 << i) - 9'h001));
      repeat (2) @(negedge clk);
      cmp_val({4'h0, vout_step}, 8'(i));
    end
    // Leave standby: startup delay, then normal
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h40);
    wait_mode(ldpms_pkg::MODE_STARTUP, 0, 3);
    cmp_bit(core_power_en, 1'b1);
    wait_mode(ldpms_pkg::MODE_NORMAL, DLY - 3, DLY + 3);
    cmp_bit(led_enable, 1'b1);
    // Overheating holds startup until the flag clears, then a full delay
    overtemp_shutdown = 1'b1;
    wait_mode(ldpms_pkg::MODE_STARTUP, 0, 3);
    repeat (3 * DLY) @(negedge clk);
    cmp_val({6'h00, mode}, {6'h00, ldpms_pkg::MODE_STARTUP});
    overtemp_shutdown = 1'b0;
    wait_mode(ldpms_pkg::MODE_NORMAL, DLY - 3, DLY + 3);
    // Converter enable from normal gives a soft-start with LEDs off
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h70);
    wait_mode(ldpms_pkg::MODE_BOOST_START, 0, 3);
    cmp_bit(led_force_off, 1'b1);
    cmp_bit(led_enable, 1'b0);
    cmp_bit(pfm_mode, 1'b1);
    wait_mode(ldpms_pkg::MODE_NORMAL, DLY - 3, DLY + 3);
    cmp_bit(conv_run, 1'b1);
    cmp_bit(autoload_en, 1'b1);
    cmp_bit(pfm_mode, 1'b0);
    // Every frequency decode, with period and duty ceiling from one clock
    for (int i = 0; i < 5; i++) begin
      ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_BOOST_FRQ, frq_code[i]);
      sw_measure(w, p);
      sw_measure(w, p);
      cmp_val(8'(p), frq_per[i]);
      cmp_val(8'(w), 8'(frq_per[i] * ldpms_pkg::MAX_DUTY_PCT / 100));
    end
    // A current trip still leaves the least pulse
    ipk_trip = 1'b1;
    sw_measure(w, p);
    cmp_val(8'(w), ldpms_pkg::MIN_ON_CYC);
    ipk_trip = 1'b0;
    // Clearing the enable stops the converter and the discharge path
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h50);
    repeat (3) @(negedge clk);
    seen = 1'b0;
    repeat (120) begin
      @(negedge clk);
      seen = seen | sw_gate;
    end
    cmp_bit(seen, 1'b0);
    cmp_bit(autoload_en, 1'b0);
    // Enable again without the dummy load: soft-start repeats, no discharge
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h60);
    wait_mode(ldpms_pkg::MODE_BOOST_START, 0, 3);
    cmp_bit(autoload_en, 1'b0);
    // Soft-start with the output above target skips pulses across a period wrap
    fb_low = 1'b0;
    seen = 1'b0;
    repeat (110) begin
      @(negedge clk);
      seen = seen | sw_gate;
    end
    cmp_bit(seen, 1'b0);
    fb_low = 1'b1;
    // Clearing the exit bit in soft-start falls back to standby
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h20);
    wait_mode(ldpms_pkg::MODE_STANDBY, 0, 3);
    // A write of any data to the reset address restores every default
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h40);
    wait_mode(ldpms_pkg::MODE_STARTUP, 0, 3);
    wait_mode(ldpms_pkg::MODE_NORMAL, DLY - 3, DLY + 3);
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_SOFT_RST, 8'hA5);
    wait_mode(ldpms_pkg::MODE_STANDBY, 0, 3);
    rd_cmp(ldpms_pkg::ADDR_ENABLES, 8'h00);
    rd_cmp(ldpms_pkg::ADDR_BOOST_OUT, 8'h3F);
    rd_cmp(ldpms_pkg::ADDR_BOOST_FRQ, 8'h07);
    // Reset pin low for one cycle
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_BOOST_OUT, 8'h00);
    external_reset_pin_n = 1'b0;
    @(negedge clk);
    external_reset_pin_n = 1'b1;
    rd_cmp(ldpms_pkg::ADDR_BOOST_OUT, 8'h3F);
    // Low second supply wins over a write made while it is low
    second_supply_ok = 1'b0;
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_BOOST_OUT, 8'h00);
    second_supply_ok = 1'b1;
    rd_cmp(ldpms_pkg::ADDR_BOOST_OUT, 8'h3F);
    // Board reset in mid-startup acts at once
    ldpms_host_model_inst.write_reg(ldpms_pkg::ADDR_ENABLES, 8'h40);
    wait_mode(ldpms_pkg::MODE_STARTUP, 0, 3);
    resetn = 1'b0;
    #1;
    cmp_val({6'h00, mode}, {6'h00, ldpms_pkg::MODE_STANDBY});
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    rd_cmp(ldpms_pkg::ADDR_ENABLES, 8'h00);
    complete_run();
  end
endmodule
